/* File: include/frl_pkg.sv */
// Package with read types, latency constants and the five frequency tables for the read-latency block.
package frl_pkg;
  localparam int          LAT_W          = 4;
  localparam int          CNT_W          = 6;
  localparam logic [3:0]  LAT_RESET      = 4'h8;
  localparam logic [5:0]  FIXED_SFDP_DUMMY = 6'h08;
  localparam logic [5:0]  FIXED_UID_DUMMY  = 6'h20;
  localparam logic [2:0]  MODE_DUAL_IO   = 3'h4;
  localparam logic [2:0]  MODE_QUAD_IO   = 3'h2;
  localparam logic [2:0]  MODE_DDR_QUAD  = 3'h1;
  localparam logic [2:0]  MODE_NONE      = 3'h0;
  localparam int          SDR_MAX_MHZ    = 133;
  localparam int          DDR_MAX_MHZ    = 80;
  localparam int          QUAD_IO_L0_MHZ = 40;
  localparam int          CLK_PERIOD_NS  = 8;

  typedef enum logic [3:0] {
    FRL_RD_PLAIN     = 4'h0,
    FRL_RD_FAST      = 4'h1,
    FRL_RD_DUAL_OUT  = 4'h2,
    FRL_RD_QUAD_OUT  = 4'h3,
    FRL_RD_DUAL_IO   = 4'h4,
    FRL_RD_QUAD_IO   = 4'h5,
    FRL_RD_DDR_QUAD  = 4'h6,
    FRL_RD_OTP       = 4'h7,
    FRL_RD_ECC       = 4'h8,
    FRL_RD_ECC_WIDE  = 4'h9,
    FRL_RD_ANY_REG   = 4'ha,
    FRL_RD_SFDP      = 4'hb,
    FRL_RD_UID       = 4'hc
  } frl_read_t;

  typedef enum logic [3:0] {
    FRL_IDLE  = 4'b0001,
    FRL_MODE  = 4'b0010,
    FRL_DUMMY = 4'b0100,
    FRL_DATA  = 4'b1000
  } frl_state_t;

  // Mode-bit cycles that follow the address for each read type.
  function automatic logic [2:0] frl_mode_cycles(input frl_read_t rd);
    unique case (rd)
      FRL_RD_DUAL_IO:  frl_mode_cycles = MODE_DUAL_IO;
      FRL_RD_QUAD_IO:  frl_mode_cycles = MODE_QUAD_IO;
      FRL_RD_DDR_QUAD: frl_mode_cycles = MODE_DDR_QUAD;
      default:         frl_mode_cycles = MODE_NONE;
    endcase
  endfunction : frl_mode_cycles

  // Dummy cycles after the mode bits; fixed reads ignore the latency code.
  function automatic logic [5:0] frl_dummy_cycles(input frl_read_t rd, input logic [3:0] lat);
    unique case (rd)
      FRL_RD_PLAIN: frl_dummy_cycles = 6'h00;
      FRL_RD_SFDP:  frl_dummy_cycles = FIXED_SFDP_DUMMY;
      FRL_RD_UID:   frl_dummy_cycles = FIXED_UID_DUMMY;
      default:      frl_dummy_cycles = {2'b00, lat};
    endcase
  endfunction : frl_dummy_cycles

  // Highest serial clock in MHz by latency code, code 0 rightmost; 0 marks a code that is not allowed.
  localparam logic [15:0][7:0] FREQ_STD_MHZ      = {8'h85, 8'h85, 8'h85, 8'h85, 8'h85, 8'h85, 8'h85, 8'h85,
                                                     8'h85, 8'h81, 8'h74, 8'h68, 8'h5c, 8'h50, 8'h42, 8'h32};
  localparam logic [15:0][7:0] FREQ_DUAL_IO_MHZ  = {8'h85, 8'h85, 8'h85, 8'h85, 8'h85, 8'h85, 8'h85, 8'h85,
                                                     8'h85, 8'h85, 8'h85, 8'h81, 8'h74, 8'h68, 8'h5c, 8'h50};
  localparam logic [15:0][7:0] FREQ_QUAD_IO_MHZ  = {8'h85, 8'h85, 8'h85, 8'h85, 8'h85, 8'h85, 8'h85, 8'h85,
                                                     8'h81, 8'h74, 8'h68, 8'h5c, 8'h50, 8'h42, 8'h35, 8'h28};
  localparam logic [15:0][7:0] FREQ_ECC_WIDE_MHZ = {8'h85, 8'h85, 8'h85, 8'h85, 8'h85, 8'h85, 8'h81, 8'h74,
                                                     8'h68, 8'h5c, 8'h50, 8'h42, 8'h35, 8'h28, 8'h1a, 8'h10};
  localparam logic [15:0][7:0] FREQ_DDR_QUAD_MHZ = {8'h50, 8'h50, 8'h50, 8'h50, 8'h50, 8'h50, 8'h50, 8'h50,
                                                     8'h50, 8'h50, 8'h44, 8'h39, 8'h2d, 8'h22, 8'h16, 8'h00};

  // Highest serial clock in MHz allowed for a read type and latency code; 0 means not allowed.
  // Fixed-latency reads ignore the code and are held only to the single-rate ceiling.
  function automatic int frl_max_mhz(input frl_read_t rd, input logic [3:0] lat);
    int f;
    f = 0;
    unique case (rd)
      FRL_RD_DUAL_IO:  f = int'(FREQ_DUAL_IO_MHZ[lat]);
      FRL_RD_QUAD_IO:  f = int'(FREQ_QUAD_IO_MHZ[lat]);
      FRL_RD_ECC_WIDE: f = int'(FREQ_ECC_WIDE_MHZ[lat]);
      FRL_RD_DDR_QUAD: f = int'(FREQ_DDR_QUAD_MHZ[lat]);
      FRL_RD_PLAIN, FRL_RD_SFDP, FRL_RD_UID: f = SDR_MAX_MHZ;
      default:         f = int'(FREQ_STD_MHZ[lat]);
    endcase
    if (rd == FRL_RD_DDR_QUAD && f > DDR_MAX_MHZ) f = DDR_MAX_MHZ;
    if (f > SDR_MAX_MHZ) f = SDR_MAX_MHZ;
    frl_max_mhz = f;
  endfunction : frl_max_mhz
endpackage : frl_pkg

/* File: include/frl_link_if.sv */
// Interface joining the flash read-latency device end and the host end.
`timescale 1ns/10ps
`default_nettype none
interface frl_link_if;
  import frl_pkg::*;
  logic        cs_n;
  logic        addr_done;
  frl_read_t   read_type;
  logic [3:0]  lat_code;
  logic        data_valid;
  logic [7:0]  data;

  modport device (
    input  cs_n,
    input  addr_done,
    input  read_type,
    input  lat_code,
    output data_valid,
    output data
  );
  modport host (
    output cs_n,
    output addr_done,
    output read_type,
    output lat_code,
    input  data_valid,
    input  data
  );
endinterface : frl_link_if
`default_nettype wire

/* File: hdl/frl_device.sv */
// Device end: counts mode and dummy cycles after the address and then returns read data.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// RQ1: dummy count from four-bit latency field
// RQ2: listed reads use the variable latency
// RQ3: host picks code fast enough for clock
// RQ4: clock never above 133 SDR, 80 DDR
// RQ5: mode bits come right after address
// RQ6: wait equals mode cycles plus latency
// RQ7: quad I/O carries two mode cycles
// RQ8: dual I/O four, DDR quad one
// RQ9: quad I/O at code zero: 40 MHz
// RQ10: plain read has no dummy cycles
// RQ11: parameter read always eight dummy cycles
// RQ12: unique id read always 32 dummy cycles
module frl_device
  import frl_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  frl_link_if.device       link,
  input  wire logic [7:0]  array_data,
  output logic             data_phase
);
  frl_state_t  state;
  frl_state_t  next_state;
  logic [5:0]  count;
  logic [5:0]  next_count;
  logic [5:0]  dummy_len;
  logic [5:0]  next_dummy_len;
  logic        valid;
  logic        next_valid;
  logic [7:0]  dout;
  logic [7:0]  next_dout;
  logic [2:0]  mode_len;
  logic [5:0]  dummy_req;
  logic        var_lat;
  logic [5:0]  fixed_len;

  // Per read type: whether the latency code applies, how many mode-bit cycles follow the address,
  // and the fixed dummy count of the reads that ignore the code.
  always_comb begin
    unique case (link.read_type)
      FRL_RD_PLAIN: begin
        var_lat   = 1'b0;
        mode_len  = MODE_NONE;
        fixed_len = 6'h00; // RQ10
      end
      FRL_RD_FAST: begin
        var_lat   = 1'b1; // RQ2
        mode_len  = MODE_NONE;
        fixed_len = 6'h00;
      end
      FRL_RD_DUAL_OUT: begin
        var_lat   = 1'b1; // RQ2
        mode_len  = MODE_NONE;
        fixed_len = 6'h00;
      end
      FRL_RD_QUAD_OUT: begin
        var_lat   = 1'b1; // RQ2
        mode_len  = MODE_NONE;
        fixed_len = 6'h00;
      end
      FRL_RD_DUAL_IO: begin
        var_lat   = 1'b1; // RQ2
        mode_len  = MODE_DUAL_IO; // RQ8
        fixed_len = 6'h00;
      end
      FRL_RD_QUAD_IO: begin
        var_lat   = 1'b1; // RQ2
        mode_len  = MODE_QUAD_IO; // RQ7
        fixed_len = 6'h00;
      end
      FRL_RD_DDR_QUAD: begin
        var_lat   = 1'b1; // RQ2
        mode_len  = MODE_DDR_QUAD; // RQ8
        fixed_len = 6'h00;
      end
      FRL_RD_OTP: begin
        var_lat   = 1'b1; // RQ2
        mode_len  = MODE_NONE;
        fixed_len = 6'h00;
      end
      FRL_RD_ECC: begin
        var_lat   = 1'b1; // RQ2
        mode_len  = MODE_NONE;
        fixed_len = 6'h00;
      end
      FRL_RD_ECC_WIDE: begin
        var_lat   = 1'b1; // RQ2
        mode_len  = MODE_NONE; // RQ8
        fixed_len = 6'h00;
      end
      FRL_RD_ANY_REG: begin
        var_lat   = 1'b1; // RQ2
        mode_len  = MODE_NONE;
        fixed_len = 6'h00;
      end
      FRL_RD_SFDP: begin
        var_lat   = 1'b0;
        mode_len  = MODE_NONE;
        fixed_len = FIXED_SFDP_DUMMY; // RQ11
      end
      FRL_RD_UID: begin
        var_lat   = 1'b0;
        mode_len  = MODE_NONE;
        fixed_len = FIXED_UID_DUMMY; // RQ12
      end
      // Unused codes behave as a plain read with no wait.
      default: begin
        var_lat   = 1'b0;
        mode_len  = MODE_NONE;
        fixed_len = 6'h00;
      end
    endcase
  end

  // Mode cycles are counted apart; the latency code only sets the dummy period.
  assign dummy_req = var_lat ? {2'b00, link.lat_code} : fixed_len; // RQ1 RQ6

  // State group: a high select drops any read in progress back to idle at once.
  always_comb begin
    next_state     = state;
    next_count     = count;
    next_dummy_len = dummy_len;
    if (link.cs_n) begin
      next_state = FRL_IDLE;
      next_count = 6'h00;
    end else begin
      unique case (state)
        FRL_IDLE: begin
          if (link.addr_done) begin
            next_dummy_len = dummy_req;
            next_count     = 6'h00;
            if (mode_len != MODE_NONE) begin
              next_state = FRL_MODE; // RQ5
              next_count = {3'b000, mode_len};
            end else if (dummy_req != 6'h00) begin
              next_state = FRL_DUMMY;
              next_count = dummy_req;
            end else begin
              next_state = FRL_DATA; // RQ10
            end
          end
        end
        FRL_MODE: begin
          next_count = count - 6'h01;
          if (count == 6'h01) begin
            // Mode cycles are separate; dummy cycles start afterwards.
            if (dummy_len != 6'h00) begin
              next_state = FRL_DUMMY; // RQ6
              next_count = dummy_len;
            end else begin
              next_state = FRL_DATA;
            end
          end
        end
        FRL_DUMMY: begin
          next_count = count - 6'h01;
          if (count == 6'h01) next_state = FRL_DATA; // RQ6
        end
        FRL_DATA: next_state = FRL_DATA;
        default: next_state = FRL_IDLE;
      endcase
    end
  end

  // A low clock enable holds the state and every count.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state     <= FRL_IDLE;
      count     <= 6'h00;
      dummy_len <= 6'h00;
    end else if (clk_en) begin
      state     <= next_state;
      count     <= next_count;
      dummy_len <= next_dummy_len;
    end
  end

  // Output group: one byte per cycle while the data state lasts and the host still selects.
  always_comb begin
    next_valid = 1'b0;
    next_dout  = dout;
    if (!link.cs_n && state == FRL_DATA) begin
      next_valid = 1'b1;
      next_dout  = array_data;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      valid <= 1'b0;
      dout  <= 8'h00;
    end else if (clk_en) begin
      valid <= next_valid;
      dout  <= next_dout;
    end
  end

  assign link.data_valid = valid;
  assign link.data       = dout;
  assign data_phase      = (state == FRL_DATA);
endmodule : frl_device
`default_nettype wire

/* File: hdl/frl_host.sv */
// Host end: issues reads and checks the latency code against the serial clock rate.
`timescale 1ns/10ps
`default_nettype none
module frl_host
  import frl_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  frl_link_if.host         link,
  input  wire logic        start,
  input  wire frl_read_t   req_type,
  input  wire logic [3:0]  req_lat,
  input  wire logic [7:0]  sck_mhz,
  input  wire logic [7:0]  req_bytes,
  output logic             busy,
  output logic             rejected,
  output logic             byte_valid,
  output logic [7:0]       byte_data
);
  logic        cs_n_r;
  logic        next_cs_n_r;
  logic        addr_r;
  logic        next_addr_r;
  frl_read_t   type_r;
  frl_read_t   next_type_r;
  logic [3:0]  lat_r;
  logic [3:0]  next_lat_r;
  logic [7:0]  left;
  logic [7:0]  next_left;
  logic        rej;
  logic        next_rej;
  logic        bv;
  logic        next_bv;
  logic [7:0]  bd;
  logic [7:0]  next_bd;
  logic        rate_ok;

  // Reads whose clock exceeds the latency code's rating are refused.
  assign rate_ok = (int'(sck_mhz) <= frl_max_mhz(req_type, req_lat)); // RQ3 RQ4 RQ9

  always_comb begin
    next_cs_n_r = cs_n_r;
    next_addr_r = 1'b0;
    next_type_r = type_r;
    next_lat_r  = lat_r;
    next_left   = left;
    next_rej    = 1'b0;
    next_bv     = 1'b0;
    next_bd     = bd;
    if (cs_n_r) begin
      if (start) begin
        if (rate_ok && req_bytes != 8'h00) begin
          next_cs_n_r = 1'b0;
          next_addr_r = 1'b1; // RQ5
          next_type_r = req_type;
          next_lat_r  = req_lat;
          next_left   = req_bytes;
        end else begin
          next_rej = 1'b1;
        end
      end
    end else if (link.data_valid) begin
      next_bv   = 1'b1;
      next_bd   = link.data;
      next_left = left - 8'h01;
      if (left == 8'h01) next_cs_n_r = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cs_n_r <= 1'b1;
      addr_r <= 1'b0;
      type_r <= FRL_RD_PLAIN;
      lat_r  <= LAT_RESET;
      left   <= 8'h00;
      rej    <= 1'b0;
      bv     <= 1'b0;
      bd     <= 8'h00;
    end else if (clk_en) begin
      cs_n_r <= next_cs_n_r;
      addr_r <= next_addr_r;
      type_r <= next_type_r;
      lat_r  <= next_lat_r;
      left   <= next_left;
      rej    <= next_rej;
      bv     <= next_bv;
      bd     <= next_bd;
    end
  end

  assign link.cs_n      = cs_n_r;
  assign link.addr_done = addr_r;
  assign link.read_type = type_r;
  assign link.lat_code  = lat_r;
  assign busy           = ~cs_n_r;
  assign rejected       = rej;
  assign byte_valid     = bv;
  assign byte_data      = bd;
endmodule : frl_host
`default_nettype wire

/* File: tb/frl_link_assertions.sv */
// Checker watching the read-latency link between the host and device ends.
`timescale 1ns/10ps
`default_nettype none
module frl_link_assertions
  import frl_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       reset_n,
  input wire logic       cs_n,
  input wire logic       addr_done,
  input wire frl_read_t  read_type,
  input wire logic [3:0] lat_code,
  input wire logic       data_valid,
  input wire logic [7:0] data
);
  logic [5:0] cnt;
  logic [5:0] next_cnt;
  logic [5:0] wait_len;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // Cycles since the address cycle, saturating, cleared while deselected.
  always_comb begin
    next_cnt = cnt;
    if (addr_done) next_cnt = 6'h01;
    else if (cs_n) next_cnt = 6'h00;
    else if (cnt != 6'h00 && cnt != 6'h3f) next_cnt = cnt + 6'h01;
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) cnt <= 6'h00;
    else cnt <= next_cnt;
  end
  always_comb begin
    case (read_type)
      FRL_RD_PLAIN:    wait_len = 6'h02;
      FRL_RD_SFDP:     wait_len = 6'h0a;
      FRL_RD_UID:      wait_len = 6'h22;
      FRL_RD_DUAL_IO:  wait_len = 6'h06 + {2'h0, lat_code};
      FRL_RD_QUAD_IO:  wait_len = 6'h04 + {2'h0, lat_code};
      FRL_RD_DDR_QUAD: wait_len = 6'h03 + {2'h0, lat_code};
      default:         wait_len = 6'h02 + {2'h0, lat_code};
    endcase
  end
  AST_WAIT_EXACT: assert property ($rose(data_valid) |-> cnt == wait_len)
    else $error("first data byte at wrong cycle");
  AST_DATA_DUE: assert property (cnt == wait_len && !cs_n |-> data_valid)
    else $error("data not returned when latency ran out");
  AST_PLAIN_NO_DUMMY: assert property (addr_done && read_type == FRL_RD_PLAIN |-> ##1 !data_valid ##1 data_valid)
    else $error("plain read returned data late or early");
  AST_PARAM_EIGHT: assert property (addr_done && read_type == FRL_RD_SFDP |-> ##1 (!data_valid) [*8] ##2 data_valid)
    else $error("parameter read dummy count wrong");
  AST_UID_32: assert property (addr_done && read_type == FRL_RD_UID |-> ##33 !data_valid ##1 data_valid)
    else $error("unique id read dummy count wrong");
  AST_QUAD_MODE: assert property (addr_done && read_type == FRL_RD_QUAD_IO && lat_code == 4'h0
    |-> ##3 !data_valid ##1 data_valid)
    else $error("quad read mode cycles wrong");
  AST_DUAL_MODE: assert property (addr_done && read_type == FRL_RD_DUAL_IO && lat_code == 4'h0
    |-> ##5 !data_valid ##1 data_valid)
    else $error("dual read mode cycles wrong");
  AST_DDR_MODE: assert property (addr_done && read_type == FRL_RD_DDR_QUAD && lat_code == 4'h1
    |-> ##3 !data_valid ##1 data_valid)
    else $error("double rate read mode cycles wrong");
  COV_UID: cover property (addr_done && read_type == FRL_RD_UID);
  COV_DATA: cover property ($rose(data_valid));
  COV_DESELECT: cover property ($rose(cs_n));
endmodule : frl_link_assertions
`default_nettype wire

/* File: tb/flash_read_latency_timing_tb_top.sv */
// Testbench running reads through both ends of the read-latency link.
`timescale 1ns/10ps
`default_nettype none
module flash_read_latency_timing_tb_top;
  import frl_pkg::*;
  logic       core_clk   = 1'b0;
  logic       reset_n    = 1'b0;
  logic       start      = 1'b0;
  frl_read_t  req_type   = FRL_RD_PLAIN;
  logic [3:0] req_lat    = 4'h0;
  logic [7:0] sck_mhz    = 8'h10;
  logic [7:0] req_bytes  = 8'h01;
  logic [7:0] array_data = 8'h00;
  logic       busy;
  logic       rejected;
  logic       byte_valid;
  logic [7:0] byte_data;
  logic       data_phase;
  logic       clk_en     = 1'b1;
  int         stall      = 0;
  int         n_errors   = 0;
  int         n_checks   = 0;
  int         seed       = 32'h0302;
  frl_link_if link ();
  frl_device frl_device_inst (.core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en), .link(link.device),
    .array_data(array_data), .data_phase(data_phase));
  frl_host frl_host_inst (.core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en), .link(link.host),
    .start(start), .req_type(req_type), .req_lat(req_lat), .sck_mhz(sck_mhz), .req_bytes(req_bytes),
    .busy(busy), .rejected(rejected), .byte_valid(byte_valid), .byte_data(byte_data));
  frl_link_assertions frl_link_assertions_inst (.core_clk(core_clk), .reset_n(reset_n), .cs_n(link.cs_n),
    .addr_done(link.addr_done), .read_type(link.read_type), .lat_code(link.lat_code),
    .data_valid(link.data_valid), .data(link.data));
  always #4 core_clk = ~core_clk;
  task automatic conclude();
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // Cycles from the start request to the first byte seen by the user.
  function automatic logic [5:0] wait_exp(input frl_read_t t, input logic [3:0] l);
    case (t)
      FRL_RD_PLAIN:    wait_exp = 6'h04;
      FRL_RD_SFDP:     wait_exp = 6'h0c;
      FRL_RD_UID:      wait_exp = 6'h24;
      FRL_RD_DUAL_IO:  wait_exp = 6'h08 + {2'h0, l};
      FRL_RD_QUAD_IO:  wait_exp = 6'h06 + {2'h0, l};
      FRL_RD_DDR_QUAD: wait_exp = 6'h05 + {2'h0, l};
      default:         wait_exp = 6'h04 + {2'h0, l};
    endcase
  endfunction : wait_exp
  task automatic run(input frl_read_t t, input logic [3:0] l, input logic [7:0] f, input logic [7:0] b,
                     input logic rj);
    int n;
    logic [7:0] d;
    d = 8'($random(seed));
    @(posedge core_clk) #1;
    array_data = d;
    req_type = t;
    req_lat = l;
    sck_mhz = f;
    req_bytes = b;
    start = 1'b1;
    @(posedge core_clk) #1;
    start = 1'b0;
    chk(rejected, rj);
    chk(link.addr_done, !rj);
    if (!rj) begin
      chk(link.read_type, t);
      n = 1;
      if (stall > 0) begin
        clk_en = 1'b0;
        repeat (stall) begin
          @(posedge core_clk) #1;
          n++;
        end
        clk_en = 1'b1;
      end
      while (byte_valid !== 1'b1 && n < 60) begin
        @(posedge core_clk) #1;
        n++;
      end
      chk(n, wait_exp(t, l) + stall);
      chk(byte_data, d);
      chk(data_phase, 1'b1);
      n = 1;
      repeat (b + 2) begin
        @(posedge core_clk) #1;
        n += byte_valid;
      end
      chk(n, b);
      chk(busy, 1'b0);
      chk(data_phase, 1'b0);
    end
  endtask : run
  initial begin
    frl_read_t t;
    logic [3:0] l;
    repeat (6) @(posedge core_clk);
    #1;
    reset_n = 1'b1;
    run(FRL_RD_PLAIN, 4'hf, 8'h10, 8'h02, 1'b0);
    run(FRL_RD_SFDP, 4'h3, 8'h10, 8'h01, 1'b0);
    run(FRL_RD_UID, 4'h0, 8'h10, 8'h02, 1'b0);
    run(FRL_RD_QUAD_IO, 4'h0, 8'h28, 8'h02, 1'b0);
    run(FRL_RD_QUAD_IO, 4'h0, 8'h29, 8'h01, 1'b1);
    run(FRL_RD_DUAL_IO, 4'h0, 8'h50, 8'h01, 1'b0);
    run(FRL_RD_DDR_QUAD, 4'h1, 8'h16, 8'h02, 1'b0);
    run(FRL_RD_DDR_QUAD, 4'h0, 8'h10, 8'h01, 1'b1);
    run(FRL_RD_DDR_QUAD, 4'h6, 8'h51, 8'h01, 1'b1);
    run(FRL_RD_FAST, 4'hf, 8'h85, 8'h01, 1'b0);
    run(FRL_RD_FAST, 4'hf, 8'h86, 8'h01, 1'b1);
    run(FRL_RD_ECC_WIDE, 4'h9, 8'h82, 8'h01, 1'b1);
    run(FRL_RD_OTP, 4'h7, 8'h10, 8'h00, 1'b1);
    run(FRL_RD_FAST, 4'h1, 8'h42, 8'h01, 1'b0);
    run(FRL_RD_DUAL_OUT, 4'h1, 8'h43, 8'h01, 1'b1);
    run(FRL_RD_QUAD_IO, 4'h3, 8'h50, 8'h01, 1'b0);
    run(FRL_RD_DUAL_IO, 4'h4, 8'h82, 8'h01, 1'b1);
    run(FRL_RD_DDR_QUAD, 4'h3, 8'h2e, 8'h01, 1'b1);
    run(FRL_RD_ECC_WIDE, 4'h3, 8'h35, 8'h01, 1'b0);
    stall = 3;
    run(FRL_RD_ANY_REG, 4'h2, 8'h10, 8'h02, 1'b0);
    stall = 0;
    for (int i = 0; i < 40; i++) begin
      t = frl_read_t'(4'($unsigned($random(seed)) % 13));
      l = 4'($random(seed));
      run(t, l, 8'h01 + 8'($unsigned($random(seed)) % 16), 8'h01 + 8'($unsigned($random(seed)) % 4),
          t == FRL_RD_DDR_QUAD && l == 4'h0);
    end
    conclude();
  end
  initial begin
    #100000;
    n_errors++;
    conclude();
  end
endmodule : flash_read_latency_timing_tb_top
`default_nettype wire
